// File: tb/field_loads.sv
// field side model: output loads with injectable short and broken wire
// assumes out_drv from the supervisor, one clock, async low reset
`timescale 1ns/100ps
`default_nettype none
module field_loads import dio_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [NCH-1:0] out_drv,
	input wire logic [NCH-1:0] short_fault,
	input wire logic [NCH-1:0] cut_wire,
	output logic [NCH-1:0] short_now,
	output logic [NCH-1:0] open_now
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			short_now <= '0;
			open_now <= '0;
		end else begin
			short_now <= out_drv & short_fault;
			open_now <= out_drv & cut_wire;
		end
	end
endmodule
`default_nettype wire

// File: tb/test_dio_supervisor.sv
// self-checking bench of the digital i/o supervisor
// assumes dio_pkg and a 10 mhz clock; hour count shortened to 3 ticks
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c, n) begin for (int k = 0; !(c); k++) begin \
	if (k == (n)) begin mismatches++; end_sim(); end @(negedge pclk); end @(posedge pclk); end
module test_dio_supervisor import dio_pkg::*; ;
	logic pclk, presetn, pready, pslverr, nv_valid, nv_save, irq;
	logic supply_err, overcurrent_err, load_short_err;
	apb_req_t req;
	field_in_t fb, fin;
	logic [31:0] prdata;
	logic [NCH-1:0][CW-1:0] nv_count, save_count;
	logic [NCH-1:0] in_out, out_drv, open_load_err, count_err, m_short, m_open, sf, cw;
	int mismatches, n_tests;
	always_comb begin
		fin = fb;
		fin.short_now = m_short;
		fin.open_now = m_open;
	end
	dio_supervisor #(.HOUR_TICKS(3)) i_dio_supervisor (.pclk(pclk), .presetn(presetn),
		.apb(req), .pready(pready), .prdata(prdata), .pslverr(pslverr), .fin(fin),
		.nv_valid(nv_valid), .nv_count(nv_count), .nv_save(nv_save),
		.save_count(save_count), .in_out(in_out), .out_drv(out_drv),
		.supply_err(supply_err), .overcurrent_err(overcurrent_err),
		.load_short_err(load_short_err), .open_load_err(open_load_err),
		.count_err(count_err), .irq(irq));
	field_loads i_field_loads (.pclk(pclk), .presetn(presetn), .out_drv(out_drv),
		.short_fault(sf), .cut_wire(cw), .short_now(m_short), .open_now(m_open));
	// ----------------------------------------
	// bus and reset helpers
	// ----------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches++;
			end_sim();
		end
		q = prdata;
		req <= '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		apb(1'b0, a, 32'h0, q);
	endtask
	task automatic do_reset(input logic v);
		@(posedge pclk);
		presetn <= 1'b0;
		nv_valid <= v;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		nv_valid <= 1'b0;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults();
		logic [31:0] q;
		rd(OFS_CTRL, q); `CHK("ctrl", 32'(CTRL_RST), q)
		`CHK("pslverr", 1'b0, pslverr)
		rd(OFS_ACTION, q); `CHK("action", 32'(ACTION_RST), q)
		rd(8'h3c, q); `CHK("unmapped", 32'h0, q)
		wr(OFS_THRESH, 32'h0);
		rd(OFS_THRESH, q); `CHK("thresh zero", 32'h1, q)
		wr(OFS_THRESH, 32'hfde8);
		rd(OFS_THRESH, q); `CHK("thresh max", 32'hfde8, q)
	endtask
	task automatic t_supply();
		fb.supply_short <= 1'b1;
		`WAITC(supply_err === 1'b1, 20)
		`CHK("irq masked", 1'b0, irq)
		wr(OFS_MASK, 32'h1);
		@(negedge pclk); `CHK("irq", 1'b1, irq)
		@(posedge pclk);
		fb.supply_short <= 1'b0;
		wr(OFS_STATUS, 32'h1);
		@(negedge pclk); `CHK("supply cleared", 1'b0, supply_err)
		wr(OFS_CTRL, 32'h054);
		fb.supply_short <= 1'b1;
		repeat (20) @(negedge pclk); `CHK("supply off", 1'b0, supply_err)
		@(posedge pclk);
		fb.supply_short <= 1'b0;
		wr(OFS_CTRL, 32'h055);
	endtask
	task automatic t_inrush();
		fb.overcurrent <= 1'b1;
		`WAITC(overcurrent_err === 1'b1, 20)
		fb.overcurrent <= 1'b0;
		wr(OFS_STATUS, 32'h2);
		wr(OFS_CTRL, 32'h057);
		fb.inrush_start <= 1'b1;
		@(posedge pclk);
		fb.inrush_start <= 1'b0;
		fb.overcurrent <= 1'b1;
		repeat (50) @(negedge pclk); `CHK("inrush masked", 1'b0, overcurrent_err)
		@(posedge pclk);
		fb.overcurrent <= 1'b0;
		wr(OFS_CTRL, 32'h055);
	endtask
	task automatic t_load(input logic man);
		wr(OFS_CTRL, man ? 32'h0d5 : 32'h055);
		fb.out_cmd <= 4'h1;
		`WAITC(out_drv[0] === 1'b1, 20)
		sf <= 4'h1;
		`WAITC(load_short_err === 1'b1, 20)
		sf <= 4'h0;
		repeat (20) @(negedge pclk); `CHK("short kept", man, load_short_err)
		do_reset(1'b0);
		@(negedge pclk); `CHK("short power-up", 1'b0, load_short_err)
		wr(OFS_CTRL, 32'h015);
		sf <= 4'h1;
		repeat (20) @(negedge pclk); `CHK("short off", 1'b0, load_short_err)
		@(posedge pclk);
		sf <= 4'h0;
		wr(OFS_CTRL, 32'h055);
	endtask
	task automatic t_open();
		cw <= 4'h1;
		repeat (20) @(negedge pclk); `CHK("open off", 4'h0, open_load_err)
		wr(OFS_CTRL, 32'h155);
		`WAITC(open_load_err[0] === 1'b1, 20)
		cw <= 4'h0;
		wr(OFS_CTRL, 32'h055);
	endtask
	task automatic t_subst();
		fb.out_cmd <= 4'h3;
		wr(OFS_ACTION, 32'h52e4);
		wr(OFS_CTRL, 32'h455);
		fb.comm_fault <= 1'b1;
		`WAITC(out_drv === 4'h6, 20)
		fb.comm_fault <= 1'b0;
		`WAITC(out_drv === 4'h3, 20)
		fb.master_idle <= 1'b1;
		`WAITC(out_drv === 4'h1, 20)
		wr(OFS_CTRL, 32'h055);
		repeat (10) @(negedge pclk); `CHK("no terminal", 4'h0, out_drv)
		@(posedge pclk);
		fb.master_idle <= 1'b0;
	endtask
	task automatic t_filter();
		logic seen;
		seen = 1'b0;
		fb.in_raw <= 4'h3;
		repeat (5000) @(posedge pclk);
		fb.in_raw <= 4'h0;
		repeat (12000) begin
			@(negedge pclk);
			seen = seen | (in_out !== 4'h0);
		end
		`CHK("short pulse", 1'b0, seen)
		wr(OFS_CTRL, 32'h041);
		fb.in_raw <= 4'h3;
		repeat (3000) @(negedge pclk); `CHK("long pulse", 1'b1, in_out[1])
		@(posedge pclk);
		fb.in_raw <= 4'h0;
		repeat (6000) @(negedge pclk); `CHK("stretched", 1'b1, in_out[1])
		repeat (9000) @(negedge pclk); `CHK("stretch end", 1'b0, in_out[1])
	endtask
	task automatic t_count();
		logic [31:0] q;
		do_reset(1'b0);
		wr(OFS_CTRL, 32'h255);
		repeat (1000) begin
			@(posedge pclk);
			fb.out_cmd <= 4'h8;
			@(posedge pclk);
			fb.out_cmd <= 4'h0;
		end
		repeat (5) @(negedge pclk);
		rd(8'h2c, q); `CHK("count", 32'd1000, q)
		`CHK("at threshold", 1'b0, count_err[3])
		fb.out_cmd <= 4'h8;
		`WAITC(count_err[3] === 1'b1, 20)
		`WAITC(nv_save === 1'b1, 4000)
		`CHK("saved", 27'd1001, save_count[3])
		nv_count[3] <= 27'd5000;
		do_reset(1'b1);
		rd(8'h2c, q); `CHK("restored", 32'd5000, q)
	endtask
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		req = '0;
		fb = '0;
		sf = '0;
		cw = '0;
		nv_valid = 1'b0;
		nv_count = '0;
		do_reset(1'b0);
		t_defaults();
		t_supply();
		t_inrush();
		t_load(1'b0);
		t_load(1'b1);
		t_open();
		t_subst();
		t_filter();
		t_count();
		end_sim();
	end
endmodule
`default_nettype wire

// File: verilog/dio_pkg.sv
// constants, field layouts and carrier types of the digital i/o supervisor
// assumes a 10 mhz apb clock and a four channel i/o unit
package dio_pkg;
	localparam int NCH = 4;
	localparam int CW = 27;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_NS = 100000;
	localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
	// all timing below in 0.1 ms ticks, except INRUSH_MS in ms
	localparam logic [7:0] FILT_0 = 8'h01;
	localparam logic [7:0] FILT_1 = 8'h0a;
	localparam logic [7:0] FILT_2 = 8'h64;
	localparam logic [7:0] FILT_3 = 8'hc8;
	localparam logic [10:0] STR_0 = 11'h00a;
	localparam logic [10:0] STR_1 = 11'h096;
	localparam logic [10:0] STR_2 = 11'h3e8;
	localparam logic [10:0] STR_3 = 11'h7d0;
	localparam int INRUSH_MS = 100;
	localparam logic [10:0] INRUSH_TICKS = 11'(INRUSH_MS * 10);
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ACTION = 8'h04;
	localparam logic [7:0] OFS_THRESH = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam logic [7:0] OFS_PINS = 8'h14;
	localparam logic [7:0] OFS_COUNT = 8'h20;
	localparam logic [10:0] CTRL_RST = 11'h055;
	localparam logic [15:0] ACTION_RST = 16'h0000;
	localparam logic [15:0] THRESH_RST = 16'h0001;
	// status bits: 0 supply short, 1 overcurrent, 2 load short,
	// 7:4 open load, 11:8 count over threshold
	localparam int ST_W = 12;
	typedef enum logic [1:0] {act_clear, act_hold, drive_on_action} action_t;
	typedef struct packed {
		logic hold_clear_src_ht;
		logic count_err_en;
		logic open_load_monitor_en;
		logic short_error_recovery_mode;
		logic load_short_monitor_en;
		logic [1:0] input_stretch_time;
		logic [1:0] filter_time;
		logic inrush_mask_en;
		logic supply_short_monitor_en;
	} ctrl_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [NCH-1:0] short_now;
		logic [NCH-1:0] open_now;
		logic [NCH-1:0] out_cmd;
		logic [NCH-1:0] in_raw;
		logic supply_short;
		logic overcurrent;
		logic inrush_start;
		logic comm_fault;
		logic master_idle;
	} field_in_t;
	typedef struct packed {
		ctrl_t ctrl;
		logic [15:0] action;
		logic [15:0] thresh;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic [31:0] prdata;
		logic [12:0] tick_cnt;
		logic [NCH-1:0] in_filt;
		logic [NCH-1:0][7:0] filt_cnt;
		logic [NCH-1:0] in_str;
		logic [NCH-1:0][10:0] str_cnt;
		logic [10:0] inrush_cnt;
		logic load_short_err;
		logic [NCH-1:0] out_drv;
		logic [NCH-1:0] out_last;
		logic [NCH-1:0][CW-1:0] count;
		logic [25:0] hour_cnt;
		logic nv_save;
		logic restored;
	} state_t;
endpackage

// File: verilog/dio_supervisor.sv
// digital i/o unit supervision: filtering, stretching, fault watch,
// output substitution and on-counters, with an apb register file
// assumes field inputs synchronous to pclk and a nonvolatile store
// that presents saved counts at reset and accepts nv_save pulses
// Summary of operation
// RULE_01 - supply short raises unit error when its monitor is enabled (default on)
// RULE_02 - optional inrush mask ignores overcurrent for 100 ms; default off
// RULE_03 - input changes shorter than 0.1/1/10/20 ms filter are dropped; default 1 ms
// RULE_04 - inputs held for 1/15/100/200 ms after a pulse; default 15 ms
// RULE_05 - output load short raises unit error when enabled (default on)
// RULE_06 - auto recovery clears load short error once short is gone
// RULE_07 - manual recovery keeps load short error until power-up
// RULE_08 - open load per channel error when enabled; default off
// RULE_09 - per channel fault and idle actions: off, hold or on
// RULE_10 - substitution settings used only when terminal source selected
// RULE_11 - per channel on-count; error when enabled and count passes threshold
// RULE_12 - effective threshold is setting times one thousand
// RULE_13 - counts saved hourly and restored after power returns
// RULE_14 - timing from a divided tick; settings default on reset
`timescale 1ns/100ps
`default_nettype none
module dio_supervisor import dio_pkg::*; #(
	parameter int HOUR_TICKS = 36000000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire apb_req_t apb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire field_in_t fin,
	input wire logic nv_valid,
	input wire logic [NCH-1:0][CW-1:0] nv_count,
	output logic nv_save,
	output logic [NCH-1:0][CW-1:0] save_count,
	output logic [NCH-1:0] in_out,
	output logic [NCH-1:0] out_drv,
	output logic supply_err,
	output logic overcurrent_err,
	output logic load_short_err,
	output logic [NCH-1:0] open_load_err,
	output logic [NCH-1:0] count_err,
	output logic irq
);
	state_t s_reg, s_next;

	function automatic logic [7:0] filt_len(input logic [1:0] sel);
		case (sel)
			2'h0: filt_len = FILT_0;
			2'h1: filt_len = FILT_1;
			2'h2: filt_len = FILT_2;
			default: filt_len = FILT_3;
		endcase
	endfunction

	function automatic logic [10:0] str_len(input logic [1:0] sel);
		case (sel)
			2'h0: str_len = STR_0;
			2'h1: str_len = STR_1;
			2'h2: str_len = STR_2;
			default: str_len = STR_3;
		endcase
	endfunction

	// x1000 by shifts: 1024 - 16 - 8, avoids a multiplier
	function automatic logic [CW-1:0] times_k(input logic [15:0] v);
		times_k = {1'b0, v, 10'h000} - {7'h00, v, 4'h0} - {8'h00, v, 3'h0};
	endfunction

	function automatic logic act_out(input logic [1:0] a, input logic last);
		case (a)
			2'(act_hold): act_out = last;
			2'(drive_on_action): act_out = 1'b1;
			default: act_out = 1'b0;
		endcase
	endfunction

	logic tick;
	logic setup;
	logic wr;
	logic inrush_on;
	logic [ST_W-1:0] ev;
	logic [NCH-1:0] on_edge;
	logic [NCH-1:0] over;
	logic [CW-1:0] thr_eff;

	always_comb begin
		s_next = s_reg;
		tick = (s_reg.tick_cnt == 13'(TICK_CYC - 1));
		setup = apb.psel && !apb.penable;
		wr = apb.psel && apb.penable && apb.pwrite;
		thr_eff = times_k(s_reg.thresh);
		// -------------------------------------------------------
		// tick divider
		// -------------------------------------------------------
		// RULE_14 timing tick
		s_next.tick_cnt = tick ? 13'h0000 : s_reg.tick_cnt + 13'h0001;
		// -------------------------------------------------------
		// input filter and stretch
		// -------------------------------------------------------
		for (int i = 0; i < NCH; i++) begin
			// RULE_03 debounce filter
			if (fin.in_raw[i] == s_reg.in_filt[i]) begin
				s_next.filt_cnt[i] = 8'h00;
			end else if (tick) begin
				if (s_reg.filt_cnt[i] + 8'h01 >= filt_len(s_reg.ctrl.filter_time)) begin
					s_next.in_filt[i] = fin.in_raw[i];
					s_next.filt_cnt[i] = 8'h00;
				end else begin
					s_next.filt_cnt[i] = s_reg.filt_cnt[i] + 8'h01;
				end
			end
			// RULE_04 pulse hold
			if (s_reg.in_filt[i]) begin
				s_next.in_str[i] = 1'b1;
				s_next.str_cnt[i] = str_len(s_reg.ctrl.input_stretch_time);
			end else if (s_reg.str_cnt[i] != 11'h000) begin
				if (tick) begin
					s_next.str_cnt[i] = s_reg.str_cnt[i] - 11'h001;
				end
			end else begin
				s_next.in_str[i] = 1'b0;
			end
		end
		// -------------------------------------------------------
		// power and load supervision
		// -------------------------------------------------------
		// RULE_02 inrush window
		inrush_on = s_reg.inrush_cnt != 11'h000;
		if (fin.inrush_start) begin
			s_next.inrush_cnt = INRUSH_TICKS;
		end else if (inrush_on && tick) begin
			s_next.inrush_cnt = s_reg.inrush_cnt - 11'h001;
		end
		// RULE_06 auto clear
		if (!s_reg.ctrl.short_error_recovery_mode) begin
			s_next.load_short_err = s_reg.ctrl.load_short_monitor_en && |fin.short_now;
		// RULE_07 manual latch
		end else if (s_reg.ctrl.load_short_monitor_en && |fin.short_now) begin
			s_next.load_short_err = 1'b1;
		end
		// -------------------------------------------------------
		// output substitution and on-counters
		// -------------------------------------------------------
		on_edge = '0;
		over = '0;
		for (int i = 0; i < NCH; i++) begin
			// RULE_10 source gate
			if (s_reg.ctrl.hold_clear_src_ht && fin.comm_fault) begin
				// RULE_09 fault action
				s_next.out_drv[i] = act_out(s_reg.action[2*i +: 2], s_reg.out_last[i]);
			end else if (s_reg.ctrl.hold_clear_src_ht && fin.master_idle) begin
				s_next.out_drv[i] = act_out(s_reg.action[8+2*i +: 2], s_reg.out_last[i]);
			end else if (fin.comm_fault || fin.master_idle) begin
				s_next.out_drv[i] = 1'b0;
			end else begin
				s_next.out_drv[i] = fin.out_cmd[i];
				s_next.out_last[i] = fin.out_cmd[i];
			end
			on_edge[i] = (s_next.in_filt[i] && !s_reg.in_filt[i])
				|| (s_next.out_drv[i] && !s_reg.out_drv[i]);
			// RULE_11 on-count
			if (on_edge[i] && s_reg.count[i] != {CW{1'b1}}) begin
				s_next.count[i] = s_reg.count[i] + 27'h0000001;
			end
			// RULE_12 scaled threshold
			over[i] = s_reg.count[i] > thr_eff;
		end
		// RULE_13 restore once after reset, then hourly save
		if (!s_reg.restored) begin
			s_next.restored = 1'b1;
			if (nv_valid) begin
				s_next.count = nv_count;
			end
		end
		s_next.nv_save = 1'b0;
		if (tick) begin
			if (s_reg.hour_cnt == 26'(HOUR_TICKS - 1)) begin
				s_next.hour_cnt = 26'h0000000;
				s_next.nv_save = 1'b1;
			end else begin
				s_next.hour_cnt = s_reg.hour_cnt + 26'h0000001;
			end
		end
		// -------------------------------------------------------
		// events and apb
		// -------------------------------------------------------
		ev = '0;
		// RULE_01 supply short
		ev[0] = s_reg.ctrl.supply_short_monitor_en && fin.supply_short;
		// RULE_02 mask overcurrent
		ev[1] = fin.overcurrent && !(s_reg.ctrl.inrush_mask_en && inrush_on);
		// RULE_05 load short
		ev[2] = s_reg.ctrl.load_short_monitor_en && |fin.short_now;
		// RULE_08 open load
		ev[7:4] = s_reg.ctrl.open_load_monitor_en ? fin.open_now : 4'h0;
		// RULE_11 count error enable
		ev[11:8] = s_reg.ctrl.count_err_en ? over : 4'h0;
		if (setup) begin
			s_next.prdata = 32'h00000000;
			case (apb.paddr)
				OFS_CTRL: s_next.prdata = 32'(s_reg.ctrl);
				OFS_ACTION: s_next.prdata = 32'(s_reg.action);
				OFS_THRESH: s_next.prdata = 32'(s_reg.thresh);
				OFS_STATUS: s_next.prdata = 32'(s_reg.status);
				OFS_MASK: s_next.prdata = 32'(s_reg.mask);
				OFS_PINS: s_next.prdata = 32'({s_reg.out_drv, s_reg.in_str});
				default: begin
					for (int i = 0; i < NCH; i++) begin
						if (apb.paddr == OFS_COUNT + 8'(4*i)) begin
							s_next.prdata = 32'(s_reg.count[i]);
						end
					end
				end
			endcase
		end
		s_next.status = s_reg.status;
		if (wr) begin
			case (apb.paddr)
				OFS_CTRL: s_next.ctrl = apb.pwdata[10:0];
				OFS_ACTION: s_next.action = apb.pwdata[15:0];
				OFS_THRESH: s_next.thresh = (apb.pwdata[15:0] == 16'h0000) ? 16'h0001 :
					apb.pwdata[15:0];
				OFS_STATUS: s_next.status = s_reg.status & ~apb.pwdata[ST_W-1:0];
				OFS_MASK: s_next.mask = apb.pwdata[ST_W-1:0];
				default: ;
			endcase
		end
		// set wins over a write-one clear in the same cycle
		s_next.status = s_next.status | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.ctrl <= CTRL_RST;
			s_reg.action <= ACTION_RST;
			s_reg.thresh <= THRESH_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = s_reg.prdata;
	assign nv_save = s_reg.nv_save;
	assign save_count = s_reg.count;
	assign in_out = s_reg.in_str;
	assign out_drv = s_reg.out_drv;
	assign supply_err = s_reg.status[0];
	assign overcurrent_err = s_reg.status[1];
	assign load_short_err = s_reg.load_short_err;
	assign open_load_err = s_reg.status[7:4];
	assign count_err = s_reg.status[11:8];
	assign irq = |(s_reg.status & s_reg.mask);

	// -------------------------------------------------------
	// checks
	// -------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_supply_err_set: assert property ( // RULE_01
		s_reg.ctrl.supply_short_monitor_en && fin.supply_short |=> supply_err)
		else $error("supply short not flagged");
	chk_supply_err_off: assert property ( // RULE_01
		!s_reg.ctrl.supply_short_monitor_en && fin.supply_short && !supply_err
		|=> !supply_err)
		else $error("supply short flagged while disabled");
	chk_inrush_mask: assert property ( // RULE_02
		s_reg.ctrl.inrush_mask_en && fin.inrush_start
		##1 s_reg.ctrl.inrush_mask_en && fin.overcurrent && !overcurrent_err
		|=> !overcurrent_err)
		else $error("overcurrent not masked after inrush");
	chk_oc_unmasked: assert property ( // RULE_02
		!s_reg.ctrl.inrush_mask_en && fin.overcurrent |=> overcurrent_err)
		else $error("overcurrent ignored without inrush mask");
	chk_filter_short: assert property ( // RULE_03
		$changed(in_out) |-> $past(s_reg.in_str) == in_out || $past(s_reg.in_filt) != 0
		|| $past(s_reg.str_cnt) == 0)
		else $error("stretched input moved without cause");
	chk_stretch_hold: assert property ( // RULE_04
		$fell(s_reg.in_filt[0]) |=> in_out[0] [*8])
		else $error("input stretch too short");
	chk_load_short_set: assert property ( // RULE_05
		s_reg.ctrl.load_short_monitor_en && |fin.short_now |=> load_short_err)
		else $error("load short not flagged");
	chk_auto_clear: assert property ( // RULE_06
		!s_reg.ctrl.short_error_recovery_mode && !(|fin.short_now) |=> !load_short_err)
		else $error("auto recovery did not clear");
	chk_manual_latch: assert property ( // RULE_07
		s_reg.ctrl.short_error_recovery_mode && load_short_err |=> load_short_err)
		else $error("manual recovery released error");
	chk_open_load: assert property ( // RULE_08
		s_reg.ctrl.open_load_monitor_en && fin.open_now[0] |=> open_load_err[0])
		else $error("open load not flagged");
	chk_fault_off: assert property ( // RULE_09
		s_reg.ctrl.hold_clear_src_ht && fin.comm_fault && s_reg.action[1:0] == 2'h0
		|=> !out_drv[0])
		else $error("fault clear action not applied");
	chk_non_ht_off: assert property ( // RULE_10
		!s_reg.ctrl.hold_clear_src_ht && (fin.comm_fault || fin.master_idle)
		|=> out_drv == '0)
		else $error("substitution used without terminal source");
	chk_count_err: assert property ( // RULE_11
		s_reg.ctrl.count_err_en && s_reg.count[3] > thr_eff |=> count_err[3])
		else $error("count error missing");
	chk_thresh_scale: assert property ( // RULE_12
		thr_eff == CW'(s_reg.thresh) * CW'(1000))
		else $error("threshold scale wrong");
	chk_count_step: assert property ( // RULE_13
		s_reg.restored && $past(s_reg.restored) |-> s_reg.count[0] - $past(s_reg.count[0]) <= 1)
		else $error("on-count jumped");
	chk_tick_period: assert property ( // RULE_14
		tick |=> !tick [*8])
		else $error("tick divider too fast");

	cov_inrush: cover property (s_reg.ctrl.inrush_mask_en && fin.inrush_start);
	cov_manual: cover property (s_reg.ctrl.short_error_recovery_mode && load_short_err);
	cov_force_on: cover property (fin.comm_fault && s_reg.ctrl.hold_clear_src_ht && out_drv[0]);
	cov_save: cover property (nv_save);
endmodule
`default_nettype wire
